// ===== bench/wdbc_chk.sv
// wdbc_chk: port-level assertions of the watchdog and bus control slice.
// assumes everything is synchronous to mclk_i; bound into wdbc_top below.
`timescale 1ns/10ps
module wdbc_chk
  import wdbc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // command and answer
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [6:0] cmd_addr_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic rsp_valid_o,
  input wire logic cmd_fail_o,
  // state and events
  input wire logic [5:0] chip_mode_i,
  input wire logic soft_reset_i,
  input wire logic restart_entry_i,
  input wire logic failsafe_entry_i,
  input wire logic [1:0] restart_trx_mode_i,
  input wire logic hw_trx_upd_i,
  input wire logic [1:0] hw_trx_mode_i,
  input wire logic wake_event_i,
  // settings
  input wire logic [1:0] dog_stop_off_o,
  input wire logic dog_window_o,
  input wire logic dog_start_on_bus_wake_o,
  input wire logic [2:0] dog_period_select_o,
  input wire logic [1:0] trx_mode_o,
  input wire logic supply_peak_select_o,
  input wire logic int_req_o
);
  logic [7:0] wd_q;
  logic quiet;
  logic pk_wr;
  // write data kept one cycle so the peak bit can be tied to its cause
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wd_q <= 8'h00;
    end else begin
      wd_q <= cmd_wdata_i;
    end
  end
  assign quiet = !soft_reset_i && !restart_entry_i && !failsafe_entry_i;
  assign pk_wr = cmd_valid_i && cmd_write_i && cmd_addr_i == WDBC_ADDR_PEAK && quiet;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  a_rsp_one_cycle: assert property (cmd_valid_i |=> rsp_valid_o)
    else $error("answer missing one cycle after a command");
  a_fail_with_rsp: assert property (cmd_fail_o |-> rsp_valid_o && $past(cmd_valid_i))
    else $error("command failure without an answer");
  a_soft_dog_load: assert property (soft_reset_i |=> dog_period_select_o == 3'h4 &&
    dog_start_on_bus_wake_o && !dog_window_o && dog_stop_off_o == 2'h0)
    else $error("watchdog settings wrong after soft reset");
  a_soft_bus_load: assert property (soft_reset_i |=> trx_mode_o == 2'h0 && !supply_peak_select_o)
    else $error("bus settings wrong after soft reset");
  a_restart_dog_val: assert property (restart_entry_i && !soft_reset_i |=>
    dog_period_select_o == 3'h4 && dog_stop_off_o == 2'h0 && $stable(dog_window_o) &&
    $stable(dog_start_on_bus_wake_o))
    else $error("watchdog settings wrong after restart");
  a_restart_bus_val: assert property (restart_entry_i && !soft_reset_i &&
    !failsafe_entry_i |=> trx_mode_o == $past(restart_trx_mode_i) &&
    $stable(supply_peak_select_o))
    else $error("bus settings wrong after restart");
  a_failsafe_wake: assert property (failsafe_entry_i && !soft_reset_i |=> trx_mode_o == 2'h1)
    else $error("transceiver not wake capable after fail-safe entry");
  a_peak_stop_hold: assert property (pk_wr && chip_mode_i == WDBC_MODE_STOP |=>
    $stable(supply_peak_select_o) && !cmd_fail_o)
    else $error("peak select changed or failed in stop");
  a_peak_write_take: assert property (pk_wr && (chip_mode_i == WDBC_MODE_INIT ||
    chip_mode_i == WDBC_MODE_NORMAL) |=> supply_peak_select_o == wd_q[5])
    else $error("peak select write not taken");
  a_hw_trx_load: assert property (hw_trx_upd_i && quiet |=> trx_mode_o == $past(hw_trx_mode_i))
    else $error("hardware transceiver update lost");
  a_wake_int_req: assert property (wake_event_i |=> int_req_o)
    else $error("wake event raised no interrupt");

  c_restart: cover property (restart_entry_i ##1 rsp_valid_o);
  c_failsafe: cover property (failsafe_entry_i);
  c_stop_peak: cover property (pk_wr && chip_mode_i == WDBC_MODE_STOP);
endmodule : wdbc_chk

bind wdbc_top wdbc_chk i_wdbc_chk (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i),
  .cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_o), .cmd_fail_o(cmd_fail_o),
  .chip_mode_i(chip_mode_i), .soft_reset_i(soft_reset_i), .restart_entry_i(restart_entry_i),
  .failsafe_entry_i(failsafe_entry_i), .restart_trx_mode_i(restart_trx_mode_i),
  .hw_trx_upd_i(hw_trx_upd_i), .hw_trx_mode_i(hw_trx_mode_i), .wake_event_i(wake_event_i),
  .dog_stop_off_o(dog_stop_off_o), .dog_window_o(dog_window_o),
  .dog_start_on_bus_wake_o(dog_start_on_bus_wake_o), .dog_period_select_o(dog_period_select_o),
  .trx_mode_o(trx_mode_o), .supply_peak_select_o(supply_peak_select_o), .int_req_o(int_req_o));

// ===== bench/wdbc_host_model.sv
// wdbc_host_model: host side of the register command port.
// assumes the device takes a command at the edge that sees it and answers one cycle later.
`timescale 1ns/10ps
module wdbc_host_model
  import wdbc_pkg::*;
(
  // clock
  input wire logic mclk_i,
  // answer from the device
  input wire logic rsp_valid_i,
  input wire logic [7:0] rsp_rdata_i,
  // command toward the device
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [6:0] cmd_addr_o,
  output logic [7:0] cmd_wdata_o
);
  int gap = 0;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_addr_o = 7'h00;
    cmd_wdata_o = 8'h00;
  end
  // gap idle cycles let the bench make the host slow
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] rd);
    repeat (gap) @(posedge mclk_i);
    @(posedge mclk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_write_o = wr;
    cmd_addr_o = a;
    cmd_wdata_o = d;
    @(posedge mclk_i);
    #1;
    rd = (rsp_valid_i === 1'b1) ? rsp_rdata_i : 8'hXX;
    cmd_valid_o = 1'b0;
    // released lines carry the inverse so a stale value never looks live
    cmd_write_o = ~wr;
    cmd_addr_o = ~a;
    cmd_wdata_o = ~d;
  endtask : xfer
  // top bit chosen so all eight watchdog bits have even parity
  task automatic wr_dog(input logic [6:0] d, output logic [7:0] w, output logic [7:0] rd);
    w = {^d, d};
    xfer(1'b1, WDBC_ADDR_DOG, w, rd);
  endtask : wr_dog
endmodule : wdbc_host_model

// ===== bench/wdbc_tb_top.sv
// wdbc_tb_top: self-checking bench of the watchdog and bus control slice.
// assumes wdbc_chk is bound in and the host model drives the command port.
`timescale 1ns/10ps
module wdbc_tb_top
  import wdbc_pkg::*;
;
  logic mclk_i, resetn_i, cmd_valid, cmd_write, rsp_valid, cmd_fail, win, bw, sum_ok, peak, irq;
  logic [6:0] cmd_addr, ev;
  logic [7:0] cmd_wdata, rsp_rdata, rd, w, prev, r, hwv;
  logic [5:0] chip_mode;
  logic [1:0] rtm, hw_trx, stop_off, trx;
  logic [2:0] per;
  logic exp_pk, fl;
  logic [31:0] seed = 32'h00012ED1;
  int error_cnt = 0;
  int checked = 0;
  wire [7:0] dog_seen = {1'b0, stop_off[0], win, bw, 1'b0, per};

  wdbc_host_model i_wdbc_host_model (.mclk_i(mclk_i), .rsp_valid_i(rsp_valid),
    .rsp_rdata_i(rsp_rdata), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
    .cmd_addr_o(cmd_addr), .cmd_wdata_o(cmd_wdata));
  wdbc_top i_wdbc_top (.mclk_i(mclk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid),
    .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
    .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata), .cmd_fail_o(cmd_fail),
    .chip_mode_i(chip_mode), .soft_reset_i(ev[6]), .restart_entry_i(ev[5]),
    .failsafe_entry_i(ev[4]), .restart_trx_mode_i(rtm), .hw_dog_upd_i(ev[3]),
    .hw_dog_off_low_i(hwv[6]), .hw_dog_off_high_i(hwv[7]), .hw_dog_bus_wake_i(hwv[4]),
    .hw_dog_period_i(hwv[2:0]), .hw_trx_upd_i(ev[2]), .hw_trx_mode_i(hw_trx),
    .wake_event_i(ev[1]), .status_event_i(ev[0]), .dog_stop_off_o(stop_off),
    .dog_window_o(win), .dog_start_on_bus_wake_o(bw), .dog_period_select_o(per),
    .dog_sum_ok_o(sum_ok), .trx_mode_o(trx), .supply_peak_select_o(peak), .int_req_o(irq));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : xs
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task automatic pulse(input logic [6:0] e);
    @(posedge mclk_i);
    #1;
    ev = e;
    @(posedge mclk_i);
    #1;
    ev = 7'h00;
  endtask : pulse
  task automatic close_out();
    $display("errors %0d of %0d checks", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // a hung handshake ends the run here
  initial begin
    #(25 * 5000);
    error_cnt++;
    close_out();
  end

  initial begin
    chip_mode = WDBC_MODE_INIT;
    ev = 7'h00;
    rtm = 2'h0;
    hwv = 8'h00;
    hw_trx = 2'h0;
    exp_pk = 1'b0;
    resetn_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    resetn_i = 1'b1;
    i_wdbc_host_model.xfer(1'b0, WDBC_ADDR_DOG, 8'h00, rd);
    chk(rd, 8'h14);
    i_wdbc_host_model.xfer(1'b0, WDBC_ADDR_TRX, 8'h00, rd);
    chk(rd, 8'h00);
    i_wdbc_host_model.xfer(1'b0, WDBC_ADDR_PEAK, 8'h00, rd);
    chk(rd, 8'h00);
    i_wdbc_host_model.xfer(1'b0, 7'h40, 8'h00, rd);
    chk(rd, 8'h00);
    prev = 8'h14;
    for (int i = 0; i < 12; i++) begin
      i_wdbc_host_model.gap = int'(xs() % 8'h03);
      r = xs();
      i_wdbc_host_model.wr_dog(r[6:0], w, rd);
      chk(rd, prev & 8'hF7);
      chk(dog_seen, w & 8'h77);
      @(posedge mclk_i);
      #1;
      // reserved bit 3 is stored as zero, so the sum is taken over what reads back
      chk({7'h00, sum_ok}, {7'h00, ~^(w & 8'hF7)});
      prev = w;
    end
    i_wdbc_host_model.gap = 0;
    i_wdbc_host_model.xfer(1'b1, WDBC_ADDR_DOG, 8'h01, rd);
    prev = 8'h01;
    @(posedge mclk_i);
    #1;
    chk({7'h00, sum_ok}, 8'h00);
    for (int m = 0; m < 4; m++) begin
      r = xs();
      i_wdbc_host_model.xfer(1'b1, WDBC_ADDR_TRX, {r[7:2], m[1:0]}, rd);
      chk({6'h00, trx}, m[7:0]);
    end
    i_wdbc_host_model.xfer(1'b0, WDBC_ADDR_TRX, 8'h00, rd);
    chk(rd, 8'h03);
    i_wdbc_host_model.xfer(1'b1, WDBC_ADDR_WAKE_INT, 8'hFF, rd);
    chk({6'h00, stop_off}, 8'h03 & {7'h01, prev[6]} | 8'h02);
    i_wdbc_host_model.xfer(1'b0, WDBC_ADDR_WAKE_INT, 8'h00, rd);
    chk(rd, 8'h04);
    // every mode, with the global interrupt bit off then on
    for (int g = 0; g < 2; g++) begin
      i_wdbc_host_model.xfer(1'b1, WDBC_ADDR_WAKE_EXT, {g[0], 7'h7F}, rd);
      for (int k = 0; k < 6; k++) begin
        chip_mode = 6'h01 << k;
        i_wdbc_host_model.xfer(1'b1, WDBC_ADDR_PEAK, {2'h0, ~exp_pk, 5'h1F}, rd);
        chk(rd, {2'h0, exp_pk, 5'h00});
        fl = (k > 2);
        if (k < 2) exp_pk = ~exp_pk;
        chk({5'h00, cmd_fail, irq, peak}, {5'h00, fl, fl & g[0], exp_pk});
      end
    end
    chip_mode = WDBC_MODE_NORMAL;
    pulse(7'h01);
    chk({7'h00, irq}, 8'h01);
    i_wdbc_host_model.xfer(1'b1, WDBC_ADDR_WAKE_EXT, 8'h00, rd);
    pulse(7'h01);
    chk({7'h00, irq}, 8'h00);
    pulse(7'h02);
    chk({7'h00, irq}, 8'h01);
    hwv = xs();
    r = xs();
    hw_trx = r[1:0];
    pulse(7'h0C);
    chk(dog_seen, {1'b0, hwv[6], prev[5], hwv[4], 1'b0, hwv[2:0]});
    chk({5'h00, stop_off[1], trx}, {5'h00, hwv[7], hw_trx});
    // peak bit set first so a restart has a one to keep
    i_wdbc_host_model.xfer(1'b1, WDBC_ADDR_PEAK, 8'h20, rd);
    exp_pk = 1'b1;
    rtm = ~hw_trx;
    pulse(7'h20);
    chk(dog_seen, {2'h0, prev[5], hwv[4], 4'h4});
    chk({3'h0, stop_off, trx, peak}, {5'h00, rtm, exp_pk});
    i_wdbc_host_model.xfer(1'b0, WDBC_ADDR_PEAK, 8'h00, rd);
    chk(rd, {2'h0, exp_pk, 5'h00});
    pulse(7'h10);
    chk({6'h00, trx}, 8'h01);
    i_wdbc_host_model.xfer(1'b1, WDBC_ADDR_PEAK, 8'h20, rd);
    pulse(7'h48);
    i_wdbc_host_model.xfer(1'b0, WDBC_ADDR_DOG, 8'h00, rd);
    chk(rd, 8'h14);
    i_wdbc_host_model.xfer(1'b0, WDBC_ADDR_PEAK, 8'h00, rd);
    chk(rd, 8'h00);
    close_out();
  end
endmodule : wdbc_tb_top

// ===== hw/wdbc_bus_reg.sv
// wdbc_bus_reg: transceiver mode, peak threshold and global interrupt bits.
// assumes the peak write strobe is already gated by operating mode.
`timescale 1ns/10ps
module wdbc_bus_reg
  import wdbc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // register traffic
  wdbc_regs_if.bus_side regs
);

  logic [7:0] trx;
  logic [7:0] peak;
  logic global_int;
  logic [7:0] next_trx;
  logic [7:0] next_peak;
  logic next_global_int;

  always_comb begin
    next_trx = trx;
    next_peak = peak;
    next_global_int = global_int;
    if (regs.soft_reset) begin
      next_trx = WDBC_TRX_POR;
      next_peak = WDBC_PEAK_POR;
      next_global_int = 1'b0;
    end else if (regs.failsafe_entry) begin
      // the bus must stay able to wake the chip
      next_trx = {6'h00, WDBC_TRX_WAKE};
    end else if (regs.restart_entry) begin
      next_trx = {6'h00, regs.restart_trx_mode};
      next_peak = peak & WDBC_PEAK_WMASK;
    end else begin
      if (regs.wr_trx) begin
        next_trx = regs.wdata & WDBC_TRX_WMASK;
      end
      if (regs.wr_peak) begin
        next_peak = regs.wdata & WDBC_PEAK_WMASK;
      end
      if (regs.wr_wake_ext) begin
        next_global_int = regs.wdata[WDBC_GLOBAL_INT_BIT];
      end
      if (regs.hw_trx_upd) begin
        next_trx = {6'h00, regs.hw_trx_mode};
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trx <= WDBC_TRX_POR;
      peak <= WDBC_PEAK_POR;
      global_int <= 1'b0;
    end else begin
      trx <= next_trx;
      peak <= next_peak;
      global_int <= next_global_int;
    end
  end

  assign regs.trx_q = trx;
  assign regs.peak_q = peak;
  assign regs.global_int_q = global_int;

endmodule : wdbc_bus_reg

// ===== hw/wdbc_dog_reg.sv
// wdbc_dog_reg: watchdog control register and the high stop-mode-off bit.
// assumes write strobes are already qualified by address; operating mode does not gate them.
`timescale 1ns/10ps
module wdbc_dog_reg
  import wdbc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // register traffic
  wdbc_regs_if.dog_side regs
);

  logic [7:0] dog;
  logic dog_off_high;
  logic [7:0] next_dog;
  logic next_dog_off_high;

  always_comb begin
    next_dog = dog;
    next_dog_off_high = dog_off_high;
    if (regs.soft_reset) begin
      next_dog = WDBC_DOG_POR;
      next_dog_off_high = 1'b0;
    end else if (regs.restart_entry) begin
      // sum, type and bus-wake bits survive a restart
      next_dog[WDBC_DOG_OFF_LOW_BIT] = 1'b0;
      next_dog[WDBC_DOG_RSVD_BIT] = 1'b0;
      next_dog[WDBC_DOG_PERIOD_LSB +: 3] = WDBC_DOG_RESTART_PERIOD;
      next_dog_off_high = 1'b0;
    end else begin
      if (regs.wr_dog) begin
        // sum bit stored as written; parity is checked, not corrected
        next_dog = regs.wdata & WDBC_DOG_WMASK;
      end
      if (regs.wr_wake_int) begin
        next_dog_off_high = regs.wdata[WDBC_DOG_OFF_HIGH_BIT];
      end
      // hardware update wins over a write in the same cycle
      if (regs.hw_dog_upd) begin
        next_dog[WDBC_DOG_OFF_LOW_BIT] = regs.hw_dog_off_low;
        next_dog[WDBC_DOG_BUS_WAKE_BIT] = regs.hw_dog_bus_wake;
        next_dog[WDBC_DOG_PERIOD_LSB +: 3] = regs.hw_dog_period;
        next_dog_off_high = regs.hw_dog_off_high;
      end
    end
    next_dog[WDBC_DOG_RSVD_BIT] = 1'b0;
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dog <= WDBC_DOG_POR;
      dog_off_high <= 1'b0;
    end else begin
      dog <= next_dog;
      dog_off_high <= next_dog_off_high;
    end
  end

  assign regs.dog_q = dog;
  assign regs.dog_off_high_q = dog_off_high;

endmodule : wdbc_dog_reg

// ===== hw/wdbc_top.sv
// wdbc_top: watchdog and bus control register slice of the basis chip.
// assumes the serial frame decoder hands over one command per cycle pulse,
// and that mode and events come from the chip state machine, all on mclk_i.
`timescale 1ns/10ps
module wdbc_top
  import wdbc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // register command from the serial decoder
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [6:0] cmd_addr_i,
  input wire logic [7:0] cmd_wdata_i,
  // register answer
  output logic rsp_valid_o,
  output logic [7:0] rsp_rdata_o,
  output logic cmd_fail_o,
  // chip state and events
  input wire logic [5:0] chip_mode_i,
  input wire logic soft_reset_i,
  input wire logic restart_entry_i,
  input wire logic failsafe_entry_i,
  input wire logic [1:0] restart_trx_mode_i,
  // hardware updates of the rwh fields
  input wire logic hw_dog_upd_i,
  input wire logic hw_dog_off_low_i,
  input wire logic hw_dog_off_high_i,
  input wire logic hw_dog_bus_wake_i,
  input wire logic [2:0] hw_dog_period_i,
  input wire logic hw_trx_upd_i,
  input wire logic [1:0] hw_trx_mode_i,
  // status sources for the interrupt line
  input wire logic wake_event_i,
  input wire logic status_event_i,
  // settings toward the watchdog, transceiver and supply
  output logic [1:0] dog_stop_off_o,
  output logic dog_window_o,
  output logic dog_start_on_bus_wake_o,
  output logic [2:0] dog_period_select_o,
  output logic dog_sum_ok_o,
  output logic [1:0] trx_mode_o,
  output logic supply_peak_select_o,
  output logic int_req_o
);

  wdbc_regs_if regs ();

  wdbc_mode_t mode;
  logic mapped;
  logic wr;
  logic peak_write_ok;
  logic peak_write_quiet;
  logic peak_write_bad;

  logic rsp_valid;
  logic [7:0] rsp_rdata;
  logic cmd_fail;
  logic int_req;
  logic sum_ok;
  logic next_rsp_valid;
  logic [7:0] next_rsp_rdata;
  logic next_cmd_fail;
  logic next_int_req;
  logic next_sum_ok;

  // even parity over all eight bits, sum bit included
  function automatic logic wdbc_even(input logic [7:0] v);
    return ~(^v);
  endfunction : wdbc_even

  // contents of a register as software sees it; zero off this slice
  function automatic logic [7:0] wdbc_read(input logic [6:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      WDBC_ADDR_DOG: r = regs.dog_q;
      WDBC_ADDR_TRX: r = regs.trx_q;
      WDBC_ADDR_PEAK: r = regs.peak_q;
      WDBC_ADDR_WAKE_INT: r = {5'h00, regs.dog_off_high_q, 2'h0};
      WDBC_ADDR_WAKE_EXT: r = {regs.global_int_q, 7'h00};
      default: r = 8'h00;
    endcase
    return r;
  endfunction : wdbc_read

  assign mode = wdbc_mode_t'(chip_mode_i);
  assign wr = cmd_valid_i & cmd_write_i;
  assign mapped = (cmd_addr_i >= WDBC_ADDR_DOG) && (cmd_addr_i <= WDBC_ADDR_WAKE_EXT);

  // peak threshold write qualified by operating mode
  always_comb begin
    peak_write_ok = 1'b0;
    peak_write_quiet = 1'b0;
    case (mode)
      WDBC_MODE_INIT: peak_write_ok = 1'b1;
      WDBC_MODE_NORMAL: peak_write_ok = 1'b1;
      WDBC_MODE_STOP: peak_write_quiet = 1'b1;
      default: peak_write_ok = 1'b0;
    endcase
  end

  // a refused peak write outside Stop is flagged; in Stop it is silent
  assign peak_write_bad = wr & (cmd_addr_i == WDBC_ADDR_PEAK) & ~peak_write_ok
                          & ~peak_write_quiet;

  // register traffic toward the two register modules
  assign regs.wdata = cmd_wdata_i;
  assign regs.wr_dog = wr & (cmd_addr_i == WDBC_ADDR_DOG);
  assign regs.wr_wake_int = wr & (cmd_addr_i == WDBC_ADDR_WAKE_INT);
  assign regs.wr_trx = wr & (cmd_addr_i == WDBC_ADDR_TRX);
  assign regs.wr_peak = wr & (cmd_addr_i == WDBC_ADDR_PEAK) & peak_write_ok;
  assign regs.wr_wake_ext = wr & (cmd_addr_i == WDBC_ADDR_WAKE_EXT);
  assign regs.soft_reset = soft_reset_i;
  assign regs.restart_entry = restart_entry_i;
  assign regs.failsafe_entry = failsafe_entry_i;
  assign regs.restart_trx_mode = restart_trx_mode_i;
  assign regs.hw_dog_upd = hw_dog_upd_i;
  assign regs.hw_dog_off_low = hw_dog_off_low_i;
  assign regs.hw_dog_off_high = hw_dog_off_high_i;
  assign regs.hw_dog_bus_wake = hw_dog_bus_wake_i;
  assign regs.hw_dog_period = hw_dog_period_i;
  assign regs.hw_trx_upd = hw_trx_upd_i;
  assign regs.hw_trx_mode = hw_trx_mode_i;

  wdbc_dog_reg u_dog (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .regs(regs.dog_side)
  );

  wdbc_bus_reg u_bus (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .regs(regs.bus_side)
  );

  // answer, failure flag and interrupt request
  always_comb begin
    next_rsp_valid = cmd_valid_i;
    // a write answers with what was there before it
    next_rsp_rdata = cmd_valid_i ? wdbc_read(cmd_addr_i) : rsp_rdata;
    next_cmd_fail = cmd_valid_i & peak_write_bad & mapped;
    // checked on the written value when a write is taken, else on the stored value, so hardware updates count a cycle later
    next_sum_ok = wdbc_even(regs.dog_q);
    if (wr & (cmd_addr_i == WDBC_ADDR_DOG) & ~soft_reset_i & ~restart_entry_i) begin
      next_sum_ok = wdbc_even(cmd_wdata_i & WDBC_DOG_WMASK);
    end
    // only wakes raise the line unless the global interrupt bit is set
    next_int_req = wake_event_i
                   | (regs.global_int_q & (status_event_i | next_cmd_fail));
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      cmd_fail <= 1'b0;
      int_req <= 1'b0;
      sum_ok <= 1'b0;
    end else begin
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
      cmd_fail <= next_cmd_fail;
      int_req <= next_int_req;
      sum_ok <= next_sum_ok;
    end
  end

  assign rsp_valid_o = rsp_valid;
  assign rsp_rdata_o = rsp_rdata;
  assign cmd_fail_o = cmd_fail;
  assign int_req_o = int_req;
  assign dog_sum_ok_o = sum_ok;

  // settings come straight from the register flops
  assign dog_stop_off_o = {regs.dog_off_high_q, regs.dog_q[WDBC_DOG_OFF_LOW_BIT]};
  assign dog_window_o = regs.dog_q[WDBC_DOG_TYPE_BIT];
  assign dog_start_on_bus_wake_o = regs.dog_q[WDBC_DOG_BUS_WAKE_BIT];
  assign dog_period_select_o = regs.dog_q[WDBC_DOG_PERIOD_LSB +: 3];
  assign trx_mode_o = regs.trx_q[1:0];
  assign supply_peak_select_o = regs.peak_q[WDBC_PEAK_BIT];

endmodule : wdbc_top

// ===== pkg/wdbc_pkg.sv
// wdbc_pkg: offsets, reset values, field positions and modes of the
// watchdog / transceiver control register slice.
// assumes a 7-bit register address and 8-bit register data from the command decoder.
package wdbc_pkg;

  // register addresses
  localparam logic [6:0] WDBC_ADDR_DOG = 7'h03;
  localparam logic [6:0] WDBC_ADDR_TRX = 7'h04;
  localparam logic [6:0] WDBC_ADDR_PEAK = 7'h05;
  localparam logic [6:0] WDBC_ADDR_WAKE_INT = 7'h06;
  localparam logic [6:0] WDBC_ADDR_WAKE_EXT = 7'h07;

  // watchdog control fields
  localparam int WDBC_DOG_SUM_BIT = 7;
  localparam int WDBC_DOG_OFF_LOW_BIT = 6;
  localparam int WDBC_DOG_TYPE_BIT = 5;
  localparam int WDBC_DOG_BUS_WAKE_BIT = 4;
  localparam int WDBC_DOG_RSVD_BIT = 3;
  localparam int WDBC_DOG_PERIOD_LSB = 0;
  localparam logic [7:0] WDBC_DOG_WMASK = 8'hF7;
  localparam logic [7:0] WDBC_DOG_POR = 8'h14;
  localparam logic [2:0] WDBC_DOG_RESTART_PERIOD = 3'h4;

  // internal and external wake control bits held here
  localparam int WDBC_DOG_OFF_HIGH_BIT = 2;
  localparam int WDBC_GLOBAL_INT_BIT = 7;

  // transceiver mode control
  localparam logic [7:0] WDBC_TRX_WMASK = 8'h03;
  localparam logic [7:0] WDBC_TRX_POR = 8'h00;
  localparam logic [1:0] WDBC_TRX_OFF = 2'h0;
  localparam logic [1:0] WDBC_TRX_WAKE = 2'h1;
  localparam logic [1:0] WDBC_TRX_RX_ONLY = 2'h2;
  localparam logic [1:0] WDBC_TRX_NORMAL = 2'h3;

  // peak threshold control
  localparam int WDBC_PEAK_BIT = 5;
  localparam logic [7:0] WDBC_PEAK_WMASK = 8'h20;
  localparam logic [7:0] WDBC_PEAK_POR = 8'h00;

  // chip operating modes, one-hot
  typedef enum logic [5:0] {
    WDBC_MODE_INIT = 6'h01,
    WDBC_MODE_NORMAL = 6'h02,
    WDBC_MODE_STOP = 6'h04,
    WDBC_MODE_SLEEP = 6'h08,
    WDBC_MODE_RESTART = 6'h10,
    WDBC_MODE_FAILSAFE = 6'h20
  } wdbc_mode_t;

endpackage : wdbc_pkg

// ===== pkg/wdbc_regs_if.sv
// wdbc_regs_if: carries write strobes, events and register contents between
// the control top and its two register modules.
// assumes every signal is synchronous to mclk_i.
`timescale 1ns/10ps
interface wdbc_regs_if;
  logic [7:0] wdata;
  logic wr_dog;
  logic wr_wake_int;
  logic wr_trx;
  logic wr_peak;
  logic wr_wake_ext;
  logic soft_reset;
  logic restart_entry;
  logic failsafe_entry;
  logic [1:0] restart_trx_mode;
  logic hw_dog_upd;
  logic hw_dog_off_low;
  logic hw_dog_off_high;
  logic hw_dog_bus_wake;
  logic [2:0] hw_dog_period;
  logic hw_trx_upd;
  logic [1:0] hw_trx_mode;
  logic [7:0] dog_q;
  logic dog_off_high_q;
  logic [7:0] trx_q;
  logic [7:0] peak_q;
  logic global_int_q;

  modport ctl (
    output wdata, wr_dog, wr_wake_int, wr_trx, wr_peak, wr_wake_ext,
    output soft_reset, restart_entry, failsafe_entry, restart_trx_mode,
    output hw_dog_upd, hw_dog_off_low, hw_dog_off_high, hw_dog_bus_wake,
    output hw_dog_period, hw_trx_upd, hw_trx_mode,
    input dog_q, dog_off_high_q, trx_q, peak_q, global_int_q
  );
  modport dog_side (
    input wdata, wr_dog, wr_wake_int, soft_reset, restart_entry,
    input hw_dog_upd, hw_dog_off_low, hw_dog_off_high, hw_dog_bus_wake, hw_dog_period,
    output dog_q, dog_off_high_q
  );
  modport bus_side (
    input wdata, wr_trx, wr_peak, wr_wake_ext, soft_reset, restart_entry,
    input failsafe_entry, restart_trx_mode, hw_trx_upd, hw_trx_mode,
    output trx_q, peak_q, global_int_q
  );
endinterface : wdbc_regs_if
